// ### common/pmw_defs.svh
// Constants for the power mode and wakeup controller.
// Assumes inclusion by bare name from the design file.
`ifndef PMW_DEFS_SVH
`define PMW_DEFS_SVH

// Register offsets on the plain register port
`define PMW_ADDR_MODE      4'h0
`define PMW_ADDR_ENABLES   4'h1
`define PMW_ADDR_STATUS    4'h2

// Mode control register fields
`define PMW_BIT_HIGH_OSCILLATOR_STOP  1
`define PMW_BIT_CLK_SEL    2
`define PMW_BIT_CPUM_LO    3
`define PMW_BIT_CPUM_HI    4

// Enable register fields
`define PMW_BIT_WT_EN      0
`define PMW_BIT_TB_EN      1
`define PMW_BIT_CC_EN      2
`define PMW_BIT_CD_EN      3
`define PMW_BIT_USB_EN     4

// Cpu mode field encodings
`define PMW_CPUM_NORMAL    2'h0
`define PMW_CPUM_SLEEP     2'h1
`define PMW_CPUM_GREEN     2'h2

`define PMW_RESET_BYTE     8'h00

// Stabilisation after sleep, in high oscillator clocks
`define PMW_WAKE_CYCLES    16384

`endif

// ### common/pmw_pkg.sv
// Types for the power mode and wakeup controller.
// No assumptions beyond a SystemVerilog compiler.
package pmw_pkg;
	typedef enum logic [2:0] {
		PMW_NORMAL = 3'b000,
		PMW_SLOW   = 3'b001,
		PMW_GREEN  = 3'b010,
		PMW_SLEEP  = 3'b011,
		PMW_STABLE = 3'b100
	} pmw_state_e;
endpackage

// ### verilog/pmw_ctrl.sv
// Operating mode and wakeup controller for a small microcontroller.
// Assumes synchronous inputs on i_ref_clk, which stands for the high clock.
//
// Overview of operation
// R1: Four modes: normal, slow, green, sleep
// R2: Setting cpu mode low bit enters sleep; the code enters sleep only on cpu mode 01, and mode 11 keeps normal or slow
// R3: Cpu mode 00 normal, 01 sleep, 10 green
// R4: Writing cpu mode 10 enters green
// R5: Clock select 1 enters slow mode
// R6: Clock select picks high or low clock
// R7: High oscillator: run, stop bit, sleep off
// R8: Low RC runs except in sleep; the code also stops it in the stabilisation state after sleep
// R9: Cpu executes only in normal, slow
// R10: Wake timer also in green; others normal/slow
// R11: USB only in normal with enable
// R12: Interrupt gating per mode
// R13: Sleep wakes on ports, USB, reset
// R14: Green also wakes on timer overflow
// R15: Sleep wake waits 16384 high clocks
// R16: Green wake resumes at once
// R17: Software waits before leaving slow mode
// R18: Running oscillator allows immediate normal return
// R19: Wake timer overflow wakes green
// R20: Wakeup clears cpu mode, keeps clock select
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defs.svh"

module pmw_ctrl
	import pmw_pkg::*;
#(
	parameter int WAKE_CYCLES = `PMW_WAKE_CYCLES
) (
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_reset,
	// Register port
	input  wire logic [3:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// Wakeup sources
	input  wire logic       i_port_zero_change,
	input  wire logic       i_port_one_change,
	input  wire logic       i_usb_toggle,
	input  wire logic       i_wake_timer_ovf,
	// Clock and function gates
	output logic            o_high_osc_run,
	output logic            o_low_rc_run,
	output logic            o_sys_clk_low,
	output logic            o_cpu_run,
	output logic            o_wake_timer_run,
	output logic            o_timer_b_run,
	output logic            o_counter_c_run,
	output logic            o_counter_d_run,
	output logic            o_usb_run,
	output logic            o_int_irq_all,
	output logic            o_int_irq_wake_timer,
	output logic            o_ext_irq_run,
	// Mode status
	output logic      [2:0] o_state
);

	localparam int CW = $clog2(WAKE_CYCLES + 1);

	pmw_state_e state_r;
	pmw_state_e state_nxt;
	logic [1:0]    cpu_mode_field_r;
	logic          clock_mode_select_r;
	logic          high_osc_stop_r;
	logic [4:0]    enables_r;
	logic [CW-1:0] stab_cnt_r;

	// Decode
	wire wr_mode    = i_wr && (i_addr == `PMW_ADDR_MODE);
	wire wr_enables = i_wr && (i_addr == `PMW_ADDR_ENABLES);
	wire wake_timer_enable   = enables_r[`PMW_BIT_WT_EN];
	wire usb_function_enable = enables_r[`PMW_BIT_USB_EN];
	wire pin_wake   = i_port_zero_change || i_port_one_change || i_usb_toggle; // see R13
	wire green_wake = pin_wake || (wake_timer_enable && i_wake_timer_ovf);     // see R14 see R19
	wire stab_done  = (stab_cnt_r == CW'(WAKE_CYCLES - 1));                   // see R15

	wire [7:0] mode_rd = {3'h0, cpu_mode_field_r, clock_mode_select_r, high_osc_stop_r, 1'b0};
	wire [7:0] rd_mux  = (i_addr == `PMW_ADDR_MODE)    ? mode_rd :
	                     (i_addr == `PMW_ADDR_ENABLES) ? {3'h0, enables_r} :
	                     (i_addr == `PMW_ADDR_STATUS)  ? {5'h00, state_r} :
	                                                     `PMW_RESET_BYTE;

	// Mode decode for a given state
	function automatic logic in_run(input pmw_state_e s);
		in_run = (s == PMW_NORMAL) || (s == PMW_SLOW);
	endfunction

	// Next state; a write of a new mode takes effect the cycle after
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PMW_NORMAL, PMW_SLOW: begin
				if (cpu_mode_field_r == `PMW_CPUM_SLEEP) begin // see R2 see R3
					state_nxt = PMW_SLEEP;
				end else if (cpu_mode_field_r == `PMW_CPUM_GREEN) begin // see R4
					state_nxt = PMW_GREEN;
				end else begin
					// Immediate return; the oscillator wait is software's job, see R18 see R17
					state_nxt = clock_mode_select_r ? PMW_SLOW : PMW_NORMAL; // see R5 see R1
				end
			end
			PMW_GREEN: begin
				if (green_wake) begin // see R16
					state_nxt = clock_mode_select_r ? PMW_SLOW : PMW_NORMAL; // see R14
				end
			end
			PMW_SLEEP: begin
				if (pin_wake) begin
					state_nxt = PMW_STABLE; // see R15
				end
			end
			PMW_STABLE: begin
				if (stab_done) begin
					state_nxt = PMW_NORMAL; // see R13
				end
			end
			default: state_nxt = PMW_NORMAL;
		endcase
	end

	wire waking = ((state_r == PMW_GREEN) && green_wake) ||
	              ((state_r == PMW_SLEEP) && pin_wake);

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			state_r             <= PMW_NORMAL;
			cpu_mode_field_r    <= `PMW_CPUM_NORMAL;
			clock_mode_select_r <= 1'b0;
			high_osc_stop_r     <= 1'b0;
			enables_r           <= 5'h00;
			stab_cnt_r          <= '0;
			o_rdata             <= `PMW_RESET_BYTE;
		end else begin
			state_r <= state_nxt;
			o_rdata <= i_rd ? rd_mux : `PMW_RESET_BYTE;
			if (waking) begin
				cpu_mode_field_r <= `PMW_CPUM_NORMAL; // see R20
			end else if (wr_mode && in_run(state_r)) begin
				cpu_mode_field_r <= {i_wdata[`PMW_BIT_CPUM_HI], i_wdata[`PMW_BIT_CPUM_LO]};
			end
			if (wr_mode && in_run(state_r)) begin
				clock_mode_select_r <= i_wdata[`PMW_BIT_CLK_SEL];
				high_osc_stop_r     <= i_wdata[`PMW_BIT_HIGH_OSCILLATOR_STOP];
			end
			if (wr_enables) begin
				enables_r <= i_wdata[4:0];
			end
			stab_cnt_r <= (state_r == PMW_STABLE) ? stab_cnt_r + 1'b1 : '0;
		end
	end

	// Per-mode gates, registered so every output is a flip-flop
	wire nrm = (state_nxt == PMW_NORMAL);
	wire run = in_run(state_nxt);
	wire grn = (state_nxt == PMW_GREEN);
	// High clock kept in normal mode even if the stop bit is left set
	wire high_oscillator = nrm || (state_nxt == PMW_STABLE) ||
	            ((run || grn) && !high_osc_stop_r);

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_high_osc_run       <= 1'b1;
			o_low_rc_run         <= 1'b1;
			o_sys_clk_low        <= 1'b0;
			o_cpu_run            <= 1'b1;
			o_wake_timer_run     <= 1'b0;
			o_timer_b_run        <= 1'b0;
			o_counter_c_run      <= 1'b0;
			o_counter_d_run      <= 1'b0;
			o_usb_run            <= 1'b0;
			o_int_irq_all        <= 1'b1;
			o_int_irq_wake_timer <= 1'b1;
			o_ext_irq_run        <= 1'b1;
			o_state              <= PMW_NORMAL;
		end else begin
			o_high_osc_run       <= high_oscillator;                                   // see R7
			o_low_rc_run         <= run || grn;                             // see R8
			// Green keeps whichever clock the select bit chose before entry
			o_sys_clk_low        <= (state_nxt == PMW_SLOW) ||
			                        (grn && clock_mode_select_r);           // see R6
			o_cpu_run            <= run;                                    // see R9
			o_wake_timer_run     <= (run || grn) && wake_timer_enable;      // see R10
			o_timer_b_run        <= run && enables_r[`PMW_BIT_TB_EN];       // see R10
			o_counter_c_run      <= run && enables_r[`PMW_BIT_CC_EN];       // see R10
			o_counter_d_run      <= run && enables_r[`PMW_BIT_CD_EN];       // see R10
			o_usb_run            <= nrm && usb_function_enable;             // see R11
			o_int_irq_all        <= run;                                    // see R12
			o_int_irq_wake_timer <= run || grn;                             // see R12
			o_ext_irq_run        <= run || grn;                             // see R12
			o_state              <= state_nxt;
		end
	end

	// Checks
	a_sleep_entry: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		in_run(state_r) && cpu_mode_field_r == `PMW_CPUM_SLEEP |=> state_r == PMW_SLEEP) // see R2
		else $error("sleep not entered");
	a_green_entry: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		in_run(state_r) && cpu_mode_field_r == `PMW_CPUM_GREEN |=> state_r == PMW_GREEN) // see R4
		else $error("green not entered");
	a_sleep_gates: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		state_r == PMW_SLEEP |-> !o_high_osc_run && !o_low_rc_run && !o_cpu_run) // see R8
		else $error("clocks running in sleep");
	a_green_cpu_off: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		state_r == PMW_GREEN |-> !o_cpu_run && !o_int_irq_all && o_ext_irq_run) // see R9
		else $error("green gating wrong");
	a_sleep_no_timer: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		state_r == PMW_SLEEP && i_wake_timer_ovf && !pin_wake |=> state_r == PMW_SLEEP) // see R13
		else $error("timer woke sleep");
	a_green_wake_now: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		state_r == PMW_GREEN && green_wake |=> in_run(state_r) && o_cpu_run) // see R16
		else $error("green wake delayed");
	a_green_resume: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		state_r == PMW_GREEN && green_wake && clock_mode_select_r |=> state_r == PMW_SLOW) // see R14
		else $error("green did not resume slow");
	a_stable_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		$rose(state_r == PMW_STABLE) |-> !o_cpu_run [*8]) // see R15
		else $error("execution during stabilisation");
	a_stable_end: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		state_r == PMW_STABLE && stab_done |=> state_r == PMW_NORMAL && o_high_osc_run) // see R15
		else $error("stabilisation end wrong");
	a_usb_gate: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		o_usb_run |-> state_r == PMW_NORMAL && $past(usb_function_enable)) // see R11
		else $error("usb active outside normal");
	a_wake_clears: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		waking |=> cpu_mode_field_r == `PMW_CPUM_NORMAL && $stable(clock_mode_select_r)) // see R20
		else $error("wake did not clear mode");

	// Clock gates; gates and state leave the same flip-flop edge

	a_normal_high_oscillator: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R7
		state_r == PMW_NORMAL |-> o_high_osc_run)
		else $error("high clock off in normal");

	a_slow_high_oscillator_stop: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R7
		state_r == PMW_SLOW |-> o_high_osc_run == !$past(high_osc_stop_r))
		else $error("high clock ignores stop bit in slow");

	a_green_high_oscillator_stop: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R7
		state_r == PMW_GREEN |-> o_high_osc_run == !$past(high_osc_stop_r))
		else $error("high clock ignores stop bit in green");

	a_lrc_running: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R8
		in_run(state_r) || state_r == PMW_GREEN |-> o_low_rc_run)
		else $error("low clock stopped outside sleep");

	a_slow_clk_low: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R6
		state_r == PMW_SLOW |-> o_sys_clk_low)
		else $error("slow mode not on low clock");

	a_normal_clk_high: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R6
		state_r == PMW_NORMAL |-> !o_sys_clk_low)
		else $error("normal mode not on high clock");

	// Function gates; enables reach the gates one edge late

	a_run_cpu_on: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R9
		in_run(state_r) |-> o_cpu_run)
		else $error("cpu stopped while running");

	a_stable_no_cpu: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R15
		state_r == PMW_STABLE |-> !o_cpu_run)
		else $error("cpu runs while stabilising");

	a_sleep_timers_off: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R10
		state_r == PMW_SLEEP |-> !o_wake_timer_run && !o_timer_b_run &&
			!o_counter_c_run && !o_counter_d_run)
		else $error("timer counting in sleep");

	a_green_timers_off: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R10
		state_r == PMW_GREEN |-> !o_timer_b_run && !o_counter_c_run && !o_counter_d_run)
		else $error("timer counting in green");

	a_wt_gate: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R10
		o_wake_timer_run |-> $past(wake_timer_enable))
		else $error("wake timer runs while disabled");

	a_usb_off: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R11
		state_r != PMW_NORMAL |-> !o_usb_run)
		else $error("usb running outside normal");

	a_run_irqs: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R12
		in_run(state_r) |-> o_int_irq_all && o_int_irq_wake_timer && o_ext_irq_run)
		else $error("interrupt gated while running");

	a_green_irq_wt: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R12
		state_r == PMW_GREEN |-> o_int_irq_wake_timer)
		else $error("wake timer interrupt gated in green");

	a_sleep_irqs_off: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R12
		state_r == PMW_SLEEP |-> !o_int_irq_all && !o_int_irq_wake_timer && !o_ext_irq_run)
		else $error("interrupt live in sleep");

	// Transitions

	a_sleep_exit_stable: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R13
		state_r == PMW_SLEEP && pin_wake |=> state_r == PMW_STABLE)
		else $error("sleep wake skipped stabilisation");

	a_sleep_stays: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R13
		state_r == PMW_SLEEP && !pin_wake |=> state_r == PMW_SLEEP)
		else $error("sleep left without wake");

	a_stable_counts: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R15
		state_r == PMW_STABLE && !stab_done |=> state_r == PMW_STABLE)
		else $error("stabilisation cut short");

	a_green_to_normal: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R14
		state_r == PMW_GREEN && green_wake && !clock_mode_select_r |=> state_r == PMW_NORMAL)
		else $error("green did not resume normal");

	a_green_timer_wake: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R19
		state_r == PMW_GREEN && wake_timer_enable && i_wake_timer_ovf |=> in_run(state_r))
		else $error("timer overflow did not wake green");

	a_green_timer_off: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R19
		state_r == PMW_GREEN && !wake_timer_enable && i_wake_timer_ovf && !pin_wake
		|=> state_r == PMW_GREEN)
		else $error("disabled timer woke green");

	a_slow_select: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R5
		in_run(state_r) && cpu_mode_field_r == `PMW_CPUM_NORMAL && clock_mode_select_r
		|=> state_r == PMW_SLOW)
		else $error("slow mode not entered");

	a_normal_return: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R18
		in_run(state_r) && cpu_mode_field_r == `PMW_CPUM_NORMAL && !clock_mode_select_r
		|=> state_r == PMW_NORMAL)
		else $error("normal mode not resumed");

	a_mode_locked: assert property (@(posedge i_ref_clk) disable iff (i_reset) // see R2
		!in_run(state_r) && !waking |=> $stable(cpu_mode_field_r))
		else $error("cpu mode changed while halted");

endmodule // pmw_ctrl
`default_nettype wire

// ### verif/pmw_ctrl_tb.sv
// Self-checking bench for the power mode and wakeup controller.
// Assumes pmw_pkg and pmw_defs.svh are visible; runs with a short wakeup count.
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defs.svh"

module pmw_ctrl_tb
	import pmw_pkg::*;
;
	localparam int WAKE = 16;
	// Table rows: enables, mode byte, expected state and gate vector
	localparam logic [7:0]  ROW_EN [6] = '{8'h1F, 8'h1F, 8'h00, 8'h00, 8'h10, 8'h1F};
	localparam logic [7:0]  ROW_MD [6] = '{8'h00, 8'h04, 8'h00, 8'h18, 8'h02, 8'h06};
	localparam logic [2:0]  ROW_ST [6] = '{3'h0, 3'h1, 3'h0, 3'h0, 3'h0, 3'h1};
	localparam logic [11:0] ROW_G  [6] = '{12'hDFF, 12'hFF7, 12'hD07, 12'hD07, 12'hD0F, 12'h7F7};

	logic        clk;
	logic        rst;
	logic [3:0]  addr;
	logic [7:0]  wdata;
	logic        wr_s;
	logic        rd_s;
	logic [3:0]  ev;
	logic [7:0]  rdata;
	logic [2:0]  state;
	wire  [11:0] gates;
	logic [7:0]  got;
	int          miscompares;
	int          n_compared;
	int          n;

	pmw_ctrl #(.WAKE_CYCLES(WAKE)) i_pmw_ctrl (
		.i_ref_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
		.i_rd(rd_s), .o_rdata(rdata), .i_port_zero_change(ev[0]), .i_port_one_change(ev[1]),
		.i_usb_toggle(ev[2]), .i_wake_timer_ovf(ev[3]), .o_high_osc_run(gates[11]),
		.o_low_rc_run(gates[10]), .o_sys_clk_low(gates[9]), .o_cpu_run(gates[8]),
		.o_wake_timer_run(gates[7]), .o_timer_b_run(gates[6]), .o_counter_c_run(gates[5]),
		.o_counter_d_run(gates[4]), .o_usb_run(gates[3]), .o_int_irq_all(gates[2]),
		.o_int_irq_wake_timer(gates[1]), .o_ext_irq_run(gates[0]), .o_state(state)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic finish_test;
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk_gates(input logic [11:0] exp, input logic [11:0] mask);
		n_compared++;
		if ((gates & mask) !== (exp & mask)) begin
			miscompares++;
			$display("[FAIL] %0t gates %h expected %h", $time, gates, exp);
		end
	endtask

	task automatic chk_byte(input logic [7:0] g, input logic [7:0] exp);
		n_compared++;
		if (g !== exp) begin
			miscompares++;
			$display("[FAIL] %0t read %h expected %h", $time, g, exp);
		end
	endtask

	// Bounded wait; a stuck state ends the run
	task automatic wait_state(input logic [2:0] exp, input int bound);
		int k;
		k = 0;
		while (state !== exp && k < bound) begin
			@(posedge clk);
			#1;
			k++;
		end
		n_compared++;
		if (state !== exp) begin
			miscompares++;
			$display("[FAIL] %0t state %h expected %h", $time, state, exp);
			finish_test();
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_s  <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr_s  <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic pulse(input int k);
		@(posedge clk);
		ev <= 4'(1 << k);
		@(posedge clk);
		ev <= 4'h0;
		#1;
	endtask

	initial begin
		miscompares = 0;
		n_compared = 0;
		rst = 1'b1;
		addr = 4'h0;
		wdata = 8'h00;
		wr_s = 1'b0;
		rd_s = 1'b0;
		ev = 4'h0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1;
		wait_state(3'h0, 1);
		chk_gates(12'hD07, 12'hFFF);
		chk_byte(rdata, 8'h00);
		$display("test reset done");
		for (int r = 0; r < 6; r++) begin
			wr(4'h1, ROW_EN[r]);
			wr(4'h0, ROW_MD[r]);
			repeat (2) @(posedge clk);
			#1;
			wait_state(ROW_ST[r], 3);
			chk_gates(ROW_G[r], 12'hFFF);
		end
		$display("test table done");
		// Green with the timer disabled must ignore its overflow
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h14);
		wait_state(3'h2, 4);
		chk_gates(12'hE03, 12'hFFF);
		pulse(3);
		repeat (3) @(posedge clk);
		#1;
		wait_state(3'h2, 0);
		wr(4'h1, 8'h01);
		@(posedge clk);
		#1;
		chk_gates(12'hE83, 12'hFFF);
		pulse(3);
		wait_state(3'h1, 2);
		chk_gates(12'hF87, 12'hFFF);
		$display("test green done");
		// Sleep from slow: timer ignored, port wakes via stabilisation
		wr(4'h0, 8'h0C);
		wait_state(3'h3, 4);
		chk_gates(12'h000, 12'hDFF);
		pulse(3);
		repeat (3) @(posedge clk);
		#1;
		wait_state(3'h3, 0);
		pulse(1);
		wait_state(3'h4, 3);
		n = 0;
		while (state === 3'h4 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk_byte(8'(n), 8'(WAKE));
		wait_state(3'h1, 3);
		rd(4'h0, got);
		chk_byte(got, 8'h04);
		wr(4'h2, 8'hFF);
		rd(4'h2, got);
		chk_byte(got, 8'h01);
		rd(4'hF, got);
		chk_byte(got, 8'h00);
		$display("test sleep done");
		// Stop the high clock in slow, restart it, wait, then go on
		wr(4'h0, 8'h06);
		@(posedge clk);
		#1;
		chk_gates(12'h000, 12'h800);
		wr(4'h0, 8'h04);
		repeat (20) @(posedge clk);
		#1;
		chk_gates(12'h800, 12'h800);
		// Oscillator running, so slow to normal needs no wait
		wr(4'h0, 8'h00);
		wait_state(3'h0, 4);
		for (int k = 0; k < 3; k++) begin
			wr(4'h0, 8'h10);
			wait_state(3'h2, 4);
			pulse(k);
			wait_state(3'h0, 2);
		end
		$display("test wake sources done");
		// Reset in mid-green returns everything to defaults
		wr(4'h0, 8'h10);
		wait_state(3'h2, 4);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		wait_state(3'h0, 1);
		chk_gates(12'hD07, 12'hFFF);
		rd(4'h0, got);
		chk_byte(got, 8'h00);
		rd(4'h1, got);
		chk_byte(got, 8'h00);
		$display("test mid reset done");
		finish_test();
	end
endmodule // pmw_ctrl_tb
`default_nettype wire
